//--- hw/access_event_comparator.sv
// access event comparator: bus watch, compare, pass count, registers
`timescale 1ns/100ps
// Summary of operation
// R1: no mode: exact address match only
// R2: area mode: start to end inclusive
// R3: area polarity selects outside range
// R4: mask zero bits excluded from address compare
// R5: masked mode polarity allows not-equal match
// R6: type selects read, write, or both
// R7: size selects byte, word, long, any
// R8: data equal and not-equal modes
// R9: greater, less, greater-equal, less-equal modes
// R10: inside and outside data range modes
// R11: inverse sign versus previous matching data
// R12: difference from previous exceeds value
// R13: history modes false before first sample
// R14: only one event may use area mode
// R15: pass count 1 to 256 before firing
// R16: data mask limits compared data bits
// R17: event is AND of all conditions
// R18: sign bit from access size top
module access_event_comparator
    import aec_pkg::*;
#(
    parameter int NE = NUM_EVENTS,
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // monitored bus access
    input  wire logic          acc_valid,
    input  wire logic          acc_write,
    input  wire logic [1:0]    acc_size,
    input  wire logic [AW-1:0] acc_addr,
    input  wire logic [DW-1:0] acc_data,
    // register port
    input  wire logic [7:0]    reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [31:0]        reg_rdata,
    // events
    output logic [NE-1:0]      event_out,
    output logic               irq
);
    // ************************************************
    // per-event settings
    // ************************************************
    logic [AW-1:0]     addr_r    [NE];
    logic [AW-1:0]     addr_end_r[NE];
    logic [AW-1:0]     addr_msk_r[NE];
    logic [DW-1:0]     data1_r   [NE];
    logic [DW-1:0]     data2_r   [NE];
    logic [DW-1:0]     dmsk_r    [NE];
    logic [CTL_W-1:0]  ctrl_r    [NE];
    logic [PASS_W-1:0] pass_r    [NE];
    logic [NE-1:0]     status_r;
    logic [NE-1:0]     mask_r;
    logic [NE-1:0]     fire;
    logic [NE-1:0]     hit_all;
    logic [NE-1:0]     restart;
    logic [NE-1:0]     area_use;
    logic [PASS_W-1:0] count     [NE];
    logic [31:0]       rdata_nxt;
    logic              slot_ok;
    logic [SLOT_W-1:0] slot;
    logic [7:0]        roff;
    logic              area_busy;

    assign slot = reg_addr[6 +: SLOT_W];
    assign roff = reg_addr & (SLOT_STRIDE - 8'h01);
    assign slot_ok = (reg_addr[7] == 1'b0) && (32'(slot) < NE);

    // ************************************************
    // area resource arbitration
    // ************************************************
    // the area comparator is single: the lowest event asking for it wins
    always_comb begin
        area_busy = 1'b0;
        for (int i = 0; i < NE; i++) begin
            area_use[i] = 1'b0;
            if (ctrl_r[i][CTL_AMODE_LO +: 2] == AM_AREA && !area_busy) begin
                area_use[i] = 1'b1; // R14
                area_busy = 1'b1;
            end
        end
    end

    // ************************************************
    // per-event compare
    // ************************************************
    genvar g;
    generate
        for (g = 0; g < NE; g++) begin : g_ev
            logic          a_hit;
            logic          t_hit;
            logic          s_hit;
            logic          d_hit;
            logic          in_rng;
            logic          pol;
            logic [1:0]    am;
            logic [1:0]    at;
            logic [1:0]    sz;
            logic [DW-1:0] prev_r;
            logic          prev_ok_r;

            assign am  = ctrl_r[g][CTL_AMODE_LO +: 2];
            assign at  = ctrl_r[g][CTL_TYPE_LO +: 2];
            assign sz  = ctrl_r[g][CTL_SIZE_LO +: 2];
            assign pol = ctrl_r[g][CTL_APOL];
            assign in_rng = (acc_addr >= addr_r[g])
                            && (acc_addr <= addr_end_r[g]); // R2

            always_comb begin
                case (am)
                    AM_EXACT: a_hit = (acc_addr == addr_r[g]); // R1
                    AM_AREA:  a_hit = area_use[g] && (in_rng ^ pol); // R3 R14
                    AM_MASK:  a_hit = (((acc_addr ^ addr_r[g])
                                       & addr_msk_r[g]) == '0) ^ pol; // R4 R5
                    default:  a_hit = 1'b0;
                endcase
                case (at)
                    AT_READ:  t_hit = !acc_write; // R6
                    AT_WRITE: t_hit = acc_write; // R6
                    default:  t_hit = 1'b1; // R6
                endcase
                s_hit = (sz == SZ_ANY) || (sz == acc_size); // R7
            end

            aec_data_cmp #(
                .W         (DW)
            ) u_cmp (
                .dmode     (ctrl_r[g][CTL_DMODE_LO +: 4]),
                .dmsk_en   (ctrl_r[g][CTL_DMSK_EN]),
                .is_signed (ctrl_r[g][CTL_SIGNED]),
                .size      (acc_size),
                .val1      (data1_r[g]),
                .val2      (data2_r[g]),
                .dmask     (dmsk_r[g]),
                .data      (acc_data),
                .prev      (prev_r),
                .prev_ok   (prev_ok_r),
                .hit       (d_hit)
            );

            // all conditions from the same access cycle
            assign hit_all[g] = acc_valid && ctrl_r[g][CTL_EN]
                                && a_hit && t_hit && s_hit && d_hit; // R17

            // history follows accesses matching address, type and size
            always_ff @(posedge sys_clk) begin
                if (!rst_n || restart[g]) begin
                    prev_r    <= '0;
                    prev_ok_r <= 1'b0; // R13
                end else if (acc_valid && a_hit && t_hit && s_hit) begin
                    prev_r    <= acc_data; // R11 R12
                    prev_ok_r <= 1'b1;
                end
            end

            aec_pass_counter #(
                .PW      (PASS_W)
            ) u_pass (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .enable  (ctrl_r[g][CTL_EN]),
                .restart (restart[g]),
                .pass_m1 (pass_r[g]),
                .match   (hit_all[g]),
                .fire    (fire[g]),
                .count   (count[g])
            );

            // a settings write restarts counting and history
            assign restart[g] = reg_wr && slot_ok && 32'(slot) == g
                                && roff != OFF_COUNT;
        end
    endgenerate

    // ************************************************
    // register writes
    // ************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NE; i++) begin
                addr_r[i]     <= '0;
                addr_end_r[i] <= '0;
                addr_msk_r[i] <= '0;
                data1_r[i]    <= '0;
                data2_r[i]    <= '0;
                dmsk_r[i]     <= '0;
                ctrl_r[i]     <= '0;
                pass_r[i]     <= PASS_ONE;
            end
        end else if (reg_wr && slot_ok) begin
            case (roff)
                OFF_ADDR:     addr_r[slot]     <= reg_wdata[AW-1:0];
                OFF_ADDR_END: addr_end_r[slot] <= reg_wdata[AW-1:0];
                OFF_ADDR_MSK: addr_msk_r[slot] <= reg_wdata[AW-1:0];
                OFF_DATA1:    data1_r[slot]    <= reg_wdata[DW-1:0];
                OFF_DATA2:    data2_r[slot]    <= reg_wdata[DW-1:0];
                OFF_DATA_MSK: dmsk_r[slot]     <= reg_wdata[DW-1:0];
                OFF_CTRL:     ctrl_r[slot]     <= reg_wdata[CTL_W-1:0];
                OFF_PASS:     pass_r[slot]     <= reg_wdata[PASS_W-1:0];
                default:      ;
            endcase
        end
    end

    // ************************************************
    // status, mask, interrupt
    // ************************************************
    // set wins over write-one-to-clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status_r <= '0;
            mask_r   <= '0;
            event_out <= '0;
        end else begin
            event_out <= fire;
            if (reg_wr && reg_addr == OFF_STATUS + OFF_GLOBAL) begin
                status_r <= (status_r & ~reg_wdata[NE-1:0]) | fire;
            end else begin
                status_r <= status_r | fire;
            end
            if (reg_wr && reg_addr == OFF_MASK + OFF_GLOBAL) begin
                mask_r <= reg_wdata[NE-1:0];
            end
        end
    end

    assign irq = |(status_r & mask_r);

    // ************************************************
    // register reads
    // ************************************************
    always_comb begin
        rdata_nxt = '0;
        if (slot_ok) begin
            case (roff)
                OFF_ADDR:     rdata_nxt = 32'(addr_r[slot]);
                OFF_ADDR_END: rdata_nxt = 32'(addr_end_r[slot]);
                OFF_ADDR_MSK: rdata_nxt = 32'(addr_msk_r[slot]);
                OFF_DATA1:    rdata_nxt = 32'(data1_r[slot]);
                OFF_DATA2:    rdata_nxt = 32'(data2_r[slot]);
                OFF_DATA_MSK: rdata_nxt = 32'(dmsk_r[slot]);
                OFF_CTRL:     rdata_nxt = 32'(ctrl_r[slot]);
                OFF_PASS:     rdata_nxt = 32'(pass_r[slot]);
                OFF_COUNT:    rdata_nxt = 32'(count[slot]);
                default:      rdata_nxt = '0;
            endcase
        end else if (reg_addr == OFF_STATUS + OFF_GLOBAL) begin
            rdata_nxt = 32'(status_r);
        end else if (reg_addr == OFF_MASK + OFF_GLOBAL) begin
            rdata_nxt = 32'(mask_r);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : '0;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    property p_exact_addr;
        @(posedge sys_clk) disable iff (!rst_n)
        (hit_all[0] && ctrl_r[0][CTL_AMODE_LO +: 2] == AM_EXACT)
            |-> acc_addr == addr_r[0];
    endproperty
    a_exact_addr: assert property (p_exact_addr) // R1
        else $error("exact mode hit on other address");

    property p_area_single;
        @(posedge sys_clk) disable iff (!rst_n)
        $onehot0(area_use);
    endproperty
    a_area_single: assert property (p_area_single) // R14
        else $error("area comparator granted twice");

    property p_type_read;
        @(posedge sys_clk) disable iff (!rst_n)
        (hit_all[0] && ctrl_r[0][CTL_TYPE_LO +: 2] == AT_READ)
            |-> !acc_write;
    endproperty
    a_type_read: assert property (p_type_read) // R6
        else $error("read-only event hit on write");

    property p_size;
        @(posedge sys_clk) disable iff (!rst_n)
        (hit_all[0] && ctrl_r[0][CTL_SIZE_LO +: 2] != SZ_ANY)
            |-> acc_size == ctrl_r[0][CTL_SIZE_LO +: 2];
    endproperty
    a_size: assert property (p_size) // R7
        else $error("size mismatch hit");

    property p_hist_first;
        @(posedge sys_clk) disable iff (!rst_n)
        (!g_ev[0].prev_ok_r && (ctrl_r[0][CTL_DMODE_LO +: 4] == DM_INVSIGN
         || ctrl_r[0][CTL_DMODE_LO +: 4] == DM_DIFF)) |-> !hit_all[0];
    endproperty
    a_hist_first: assert property (p_hist_first) // R13
        else $error("history mode hit without sample");

    property p_fire_count;
        @(posedge sys_clk) disable iff (!rst_n)
        fire[0] |-> hit_all[0] && count[0] == pass_r[0];
    endproperty
    a_fire_count: assert property (p_fire_count) // R15
        else $error("fire before pass count reached");

    property p_event_out;
        @(posedge sys_clk) disable iff (!rst_n)
        fire[0] |=> event_out[0] && status_r[0];
    endproperty
    a_event_out: assert property (p_event_out) // R17
        else $error("fire not reported");

    property p_eq_data;
        @(posedge sys_clk) disable iff (!rst_n)
        (hit_all[0] && ctrl_r[0][CTL_DMODE_LO +: 4] == DM_EQ
         && !ctrl_r[0][CTL_DMSK_EN]) |-> acc_data == data1_r[0];
    endproperty
    a_eq_data: assert property (p_eq_data) // R8
        else $error("equal mode hit on other data");

    property p_rd_next;
        @(posedge sys_clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == '0;
    endproperty
    a_rd_next: assert property (p_rd_next)
        else $error("read data outside read slot");

    c_fire:  cover property (@(posedge sys_clk) disable iff (!rst_n)
                             fire[0]);
    c_area:  cover property (@(posedge sys_clk) disable iff (!rst_n)
                             hit_all[0] && area_use[0]);
    c_irq:   cover property (@(posedge sys_clk) disable iff (!rst_n)
                             irq);
endmodule

//--- hw/aec_pkg.sv
// constants and types for the access event comparator
package aec_pkg;
    localparam int          ADDR_W       = 32;
    localparam int          DATA_W       = 32;
    localparam int          PASS_W       = 8;
    localparam int          NUM_EVENTS   = 2;
    localparam int          SLOT_W       = 1;
    localparam logic [7:0]  OFF_GLOBAL   = 8'h80;
    // ************************************************
    // register offsets (byte addresses, one word each)
    // ************************************************
    localparam logic [7:0]  OFF_ADDR     = 8'h00;
    localparam logic [7:0]  OFF_ADDR_END = 8'h04;
    localparam logic [7:0]  OFF_ADDR_MSK = 8'h08;
    localparam logic [7:0]  OFF_DATA1    = 8'h0C;
    localparam logic [7:0]  OFF_DATA2    = 8'h10;
    localparam logic [7:0]  OFF_DATA_MSK = 8'h14;
    localparam logic [7:0]  OFF_CTRL     = 8'h18;
    localparam logic [7:0]  OFF_PASS     = 8'h1C;
    localparam logic [7:0]  OFF_STATUS   = 8'h20;
    localparam logic [7:0]  OFF_MASK     = 8'h24;
    localparam logic [7:0]  OFF_COUNT    = 8'h28;
    localparam logic [7:0]  SLOT_STRIDE  = 8'h40;
    // ************************************************
    // control word fields
    // ************************************************
    localparam int          CTL_EN       = 0;
    localparam int          CTL_AMODE_LO = 1;
    localparam int          CTL_APOL     = 3;
    localparam int          CTL_TYPE_LO  = 4;
    localparam int          CTL_SIZE_LO  = 6;
    localparam int          CTL_DMODE_LO = 8;
    localparam int          CTL_DMSK_EN  = 12;
    localparam int          CTL_SIGNED   = 13;
    localparam int          CTL_W        = 14;
    localparam logic [31:0] DATA_ALL     = 32'hFFFFFFFF;
    localparam logic [PASS_W-1:0] PASS_ONE = 8'h00;
    typedef enum logic [1:0] {
        AM_EXACT = 2'h0, AM_AREA = 2'h1, AM_MASK = 2'h2
    } amode_t;
    typedef enum logic [1:0] {
        AT_RW = 2'h0, AT_READ = 2'h1, AT_WRITE = 2'h2
    } atype_t;
    typedef enum logic [1:0] {
        SZ_ANY = 2'h0, SZ_BYTE = 2'h1, SZ_WORD = 2'h2, SZ_LONG = 2'h3
    } asize_t;
    typedef enum logic [3:0] {
        DM_NONE = 4'h0, DM_EQ = 4'h1, DM_NE = 4'h2, DM_GT = 4'h3,
        DM_LT = 4'h4, DM_GE = 4'h5, DM_LE = 4'h6, DM_IN = 4'h7,
        DM_OUT = 4'h8, DM_INVSIGN = 4'h9, DM_DIFF = 4'hA
    } dmode_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001, ST_COUNT = 3'b010, ST_FIRED = 3'b100
    } cnt_state_t;
endpackage

//--- hw/aec_data_cmp.sv
// data comparison of one access against programmed values
`timescale 1ns/100ps
module aec_data_cmp
    import aec_pkg::*;
#(
    parameter int W = DATA_W
) (
    // settings
    input  wire logic [3:0]   dmode,
    input  wire logic         dmsk_en,
    input  wire logic         is_signed,
    input  wire logic [1:0]   size,
    input  wire logic [W-1:0] val1,
    input  wire logic [W-1:0] val2,
    input  wire logic [W-1:0] dmask,
    // access and history
    input  wire logic [W-1:0] data,
    input  wire logic [W-1:0] prev,
    input  wire logic         prev_ok,
    // result
    output logic              hit
);
    logic [W-1:0] m;
    logic [W-1:0] d;
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic [W-1:0] p;
    logic [W:0]   diff;
    logic         sd;
    logic         sp;
    logic         gt1;
    logic         lt1;
    logic         gt2;

    // sign taken from top bit of the access size; no-size treated as long
    function automatic logic sbit(input logic [W-1:0] x,
                                  input logic [1:0] sz);
        case (sz)
            SZ_BYTE: sbit = x[7];
            SZ_WORD: sbit = x[15];
            default: sbit = x[W-1];
        endcase
    endfunction

    // sign-extend so that signed order is plain two's complement order
    function automatic logic [W-1:0] sext(input logic [W-1:0] x,
                                          input logic [1:0] sz);
        case (sz)
            SZ_BYTE: sext = {{(W-8){x[7]}}, x[7:0]};
            SZ_WORD: sext = {{(W-16){x[15]}}, x[15:0]};
            default: sext = x;
        endcase
    endfunction

    always_comb begin
        m = dmsk_en ? dmask : DATA_ALL[W-1:0]; // R16
        d = is_signed ? sext(data & m, size) : (data & m); // R18
        a = is_signed ? sext(val1 & m, size) : (val1 & m);
        b = is_signed ? sext(val2 & m, size) : (val2 & m);
        p = is_signed ? sext(prev & m, size) : (prev & m);
        sd = sbit(data, size); // R18
        sp = sbit(prev, size);
        if (is_signed) begin
            gt1 = $signed(d) > $signed(a);
            lt1 = $signed(d) < $signed(a);
            gt2 = $signed(d) > $signed(b);
        end else begin
            gt1 = d > a;
            lt1 = d < a;
            gt2 = d > b;
        end
        diff = {is_signed & d[W-1], d} - {is_signed & p[W-1], p};
        diff = diff[W] ? -diff : diff;
        case (dmode)
            DM_NONE:    hit = 1'b1;
            DM_EQ:      hit = (d == a); // R8
            DM_NE:      hit = (d != a); // R8
            DM_GT:      hit = gt1; // R9
            DM_LT:      hit = lt1; // R9
            DM_GE:      hit = !lt1; // R9
            DM_LE:      hit = !gt1; // R9
            DM_IN:      hit = !lt1 && !gt2; // R10
            DM_OUT:     hit = lt1 || gt2; // R10
            DM_INVSIGN: hit = prev_ok && (sd != sp); // R11 R13
            DM_DIFF:    hit = prev_ok && (diff > {1'b0, val2}); // R12 R13
            default:    hit = 1'b0;
        endcase
    end
endmodule

//--- hw/aec_pass_counter.sv
// pass counter that fires after n qualifying accesses
`timescale 1ns/100ps
module aec_pass_counter
    import aec_pkg::*;
#(
    parameter int PW = PASS_W
) (
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // control
    input  wire logic          enable,
    input  wire logic          restart,
    input  wire logic [PW-1:0] pass_m1,
    input  wire logic          match,
    // result
    output logic               fire,
    output logic [PW-1:0]      count
);
    cnt_state_t state_r;
    logic [PW-1:0] count_r;

    assign count = count_r;
    // fire in the cycle of the n-th match; counts 1..256 as value+1
    assign fire = enable && match && (state_r != ST_FIRED)
                  && (count_r == pass_m1); // R15

    always_ff @(posedge sys_clk) begin
        if (!rst_n || restart || !enable) begin
            state_r <= ST_IDLE;
            count_r <= PASS_ONE;
        end else begin
            case (state_r)
                ST_IDLE, ST_COUNT: begin
                    if (fire) begin
                        state_r <= ST_FIRED;
                    end else if (match) begin
                        state_r <= ST_COUNT;
                        count_r <= count_r + 1'b1; // R15
                    end
                end
                ST_FIRED: state_r <= ST_FIRED;
                default:  state_r <= ST_IDLE;
            endcase
        end
    end
endmodule

//--- verification/aec_bus_model.sv
// bus master model issuing monitored data accesses
`timescale 1ns/100ps
module aec_bus_model (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // request from bench
    input  wire logic        req,
    input  wire logic        req_write,
    input  wire logic [1:0]  req_size,
    input  wire logic [31:0] req_addr,
    input  wire logic [31:0] req_data,
    // monitored bus
    output logic             acc_valid,
    output logic             acc_write,
    output logic [1:0]       acc_size,
    output logic [31:0]      acc_addr,
    output logic [31:0]      acc_data
);
    // idle bus inverts its last value, so stale fields never match
    always_ff @(posedge sys_clk) begin
        acc_valid <= rst_n & req;
        if (!rst_n) begin
            acc_write <= 1'b0;
            acc_size  <= 2'h0;
            acc_addr  <= 32'h0;
            acc_data  <= 32'h0;
        end else if (req) begin
            acc_write <= req_write;
            acc_size  <= req_size;
            acc_addr  <= req_addr;
            acc_data  <= req_data;
        end else begin
            acc_write <= ~acc_write;
            acc_size  <= ~acc_size;
            acc_addr  <= ~acc_addr;
            acc_data  <= ~acc_data;
        end
    end
endmodule

//--- verification/tb_access_event_comparator.sv
// self-checking testbench for the access event comparator
`timescale 1ns/100ps
module tb_access_event_comparator
    import aec_pkg::*;
;
    logic        sys_clk, rst_n, req, req_write, reg_wr, reg_rd, irq;
    logic        acc_valid, acc_write;
    logic [1:0]  req_size, acc_size, event_out;
    logic [31:0] req_addr, req_data, acc_addr, acc_data;
    logic [31:0] reg_wdata, reg_rdata;
    logic [7:0]  reg_addr;
    int          failures, checked, cycles;

    aec_bus_model aec_bus_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .req(req), .req_write(req_write), .req_size(req_size),
        .req_addr(req_addr), .req_data(req_data), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_size(acc_size), .acc_addr(acc_addr),
        .acc_data(acc_data));
    access_event_comparator access_event_comparator_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_size(acc_size), .acc_addr(acc_addr),
        .acc_data(acc_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .event_out(event_out), .irq(irq));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // whole run needs about 1050 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", e, reg_rdata);
    endtask
    // event is a one-cycle pulse, so it is sampled right after the edge
    task automatic acc(logic w, logic [1:0] s, logic [31:0] a, d,
                       logic [1:0] e);
        @(posedge sys_clk);
        req       <= 1'b1;
        req_write <= w;
        req_size  <= s;
        req_addr  <= a;
        req_data  <= d;
        @(posedge sys_clk);
        req <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("event_out", {30'h0, e}, {30'h0, event_out});
    endtask
    task automatic try(logic [15:0] c, logic w, logic [1:0] s,
                       logic [31:0] a, d, logic e);
        wr(OFF_CTRL, {16'h0, c});
        acc(w, s, a, d, {1'b0, e});
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_reset();
        rd(OFF_CTRL, 32'h0);
        rd(OFF_COUNT, 32'h0);
        wr(8'hFC, 32'h5A);
        rd(8'hFC, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_data();
        logic [15:0] ct [8] = '{16'h0101, 16'h0201, 16'h0301, 16'h0401,
                                16'h0501, 16'h0601, 16'h0701, 16'h0801};
        logic [7:0]  dh [8] = '{8'h10, 8'h11, 8'h11, 8'h0F,
                                8'h10, 8'h10, 8'h20, 8'h21};
        logic [7:0]  dm [8] = '{8'h11, 8'h10, 8'h10, 8'h10,
                                8'h0F, 8'h11, 8'h21, 8'h10};
        wr(OFF_ADDR, 32'h1000);
        wr(OFF_DATA1, 32'h10);
        wr(OFF_DATA2, 32'h20);
        wr(OFF_DATA_MSK, 32'h0F);
        for (int i = 0; i < 8; i++) begin
            try(ct[i], 1'b0, 2'h3, 32'h1000, {24'h0, dh[i]}, 1'b1);
            try(ct[i], 1'b0, 2'h3, 32'h1000, {24'h0, dm[i]}, 1'b0);
        end
        try(16'h1101, 1'b0, 2'h3, 32'h1000, 32'hA0, 1'b1);
        try(16'h0101, 1'b0, 2'h3, 32'h1000, 32'hA0, 1'b0);
        try(16'h2341, 1'b0, 2'h1, 32'h1000, 32'h80, 1'b0);
        try(16'h0341, 1'b0, 2'h1, 32'h1000, 32'h80, 1'b1);
        $display("data test done");
    endtask
    task automatic t_hist();
        wr(OFF_CTRL, 32'h2941);
        acc(1'b0, 2'h1, 32'h1000, 32'h7F, 2'h0);
        acc(1'b0, 2'h1, 32'h1000, 32'h80, 2'h1);
        wr(OFF_CTRL, 32'h0A01);
        acc(1'b1, 2'h3, 32'h1000, 32'h100, 2'h0);
        acc(1'b1, 2'h3, 32'h1000, 32'h110, 2'h0);
        acc(1'b1, 2'h3, 32'h1000, 32'h140, 2'h1);
        $display("history test done");
    endtask
    task automatic t_addr();
        logic [15:0] ct [5] = '{16'h1, 16'h3, 16'hB, 16'h5, 16'hD};
        logic [15:0] ah [5] = '{16'h1000, 16'h2000, 16'h2004,
                                16'h1FFF, 16'h2000};
        logic [15:0] am [5] = '{16'h1004, 16'h2004, 16'h1800,
                                16'h2000, 16'h1ABC};
        logic [15:0] cs [5] = '{16'h11, 16'h21, 16'h41, 16'h81, 16'hC1};
        logic [2:0]  sh [5] = '{3'h3, 3'h7, 3'h1, 3'h2, 3'h3};
        logic [2:0]  sm [5] = '{3'h7, 3'h3, 3'h2, 3'h3, 3'h1};
        wr(OFF_ADDR_END, 32'h2000);
        wr(OFF_ADDR_MSK, 32'hF000);
        for (int i = 0; i < 5; i++) begin
            try(ct[i], 1'b0, 2'h3, {16'h0, ah[i]}, 32'h0, 1'b1);
            try(ct[i], 1'b0, 2'h3, {16'h0, am[i]}, 32'h0, 1'b0);
            try(cs[i], sh[i][2], sh[i][1:0], 32'h1000, 32'h0, 1'b1);
            try(cs[i], sm[i][2], sm[i][1:0], 32'h1000, 32'h0, 1'b0);
        end
        $display("address test done");
    endtask
    task automatic t_area();
        wr(SLOT_STRIDE + OFF_ADDR, 32'h1000);
        wr(SLOT_STRIDE + OFF_ADDR_END, 32'h2000);
        wr(SLOT_STRIDE + OFF_CTRL, 32'h3);
        try(16'h3, 1'b0, 2'h3, 32'h1800, 32'h0, 1'b1);
        wr(OFF_CTRL, 32'h1);
        acc(1'b0, 2'h3, 32'h1800, 32'h0, 2'h2);
        wr(SLOT_STRIDE + OFF_CTRL, 32'h0);
        $display("area test done");
    endtask
    task automatic t_pass();
        wr(8'hA0, 32'h3);
        wr(8'hA4, 32'h1);
        wr(OFF_PASS, 32'hFF);
        wr(OFF_CTRL, 32'h1);
        repeat (255) acc(1'b0, 2'h3, 32'h1000, 32'h0, 2'h0);
        acc(1'b0, 2'h3, 32'h1000, 32'h0, 2'h1);
        chk("irq", 32'h1, {31'h0, irq});
        acc(1'b0, 2'h3, 32'h1000, 32'h0, 2'h0);
        rd(8'hA0, 32'h1);
        wr(8'hA4, 32'h0);
        #1;
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'hA0, 32'h1);
        wr(8'hA4, 32'h1);
        rd(8'hA0, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        $display("pass and interrupt test done");
    endtask

    initial begin
        {rst_n, req, req_write, reg_wr, reg_rd} = 5'h0;
        {req_size, req_addr, req_data, reg_addr, reg_wdata} = 'h0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_data();
        t_hist();
        t_addr();
        t_area();
        t_pass();
        end_of_test();
    end
endmodule
